// *** i2c_host_model.sv ***
// serial bus controller model that drives the target from the host side
`timescale 1ns/1ps
module i2c_host_model #(
    parameter int Q = 25
) (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    // quarter period of 250 ns keeps scl high and low above their minimum
    task automatic start();
        sda_pull <= 1'b1;
        w(2 * Q);
        scl <= 1'b0;
        w(Q);
    endtask
    // repeated start: release data while scl low, raise scl, then a normal start
    task automatic rstart();
        sda_pull <= 1'b0;
        w(Q);
        scl <= 1'b1;
        w(Q);
        start();
    endtask
    // long idle after stop honours the bus free time
    task automatic stop();
        sda_pull <= 1'b1;
        w(Q);
        scl <= 1'b1;
        w(Q);
        sda_pull <= 1'b0;
        w(2 * Q);
    endtask
    // data changes only while scl is low, sampled mid high phase
    task automatic clk_bit(input logic b, output logic r);
        sda_pull <= !b;
        w(Q);
        scl <= 1'b1;
        w(Q);
        r = sda;
        w(Q);
        scl <= 1'b0;
        w(Q);
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, r);
        ack = !r;
    endtask
    // last byte is refused with a high ack bit
    task automatic get(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(last, r);
    endtask
endmodule

// *** port_fault_timer.sv ***
// per-port overcurrent fault timer and switch drive
`timescale 1ns/1ps
module port_fault_timer #(
    parameter int unsigned LIMIT = 5900000
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic overcurrent,
    output logic switch_drive,
    output logic fault_pulse
);
    localparam int unsigned CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);
    logic [CW-1:0] cnt_r;
    logic tripped_r;
    wire expire = enable && overcurrent && !tripped_r && (cnt_r == LAST);

    // decays one count per cycle below threshold; tolerates brief surges only
    always_ff @(posedge clk) begin
        if (srst || !enable) begin
            cnt_r <= '0;
            tripped_r <= 1'b0;
        end else if (expire) begin
            cnt_r <= '0;
            tripped_r <= 1'b1;
        end else if (overcurrent && !tripped_r) begin
            cnt_r <= cnt_r + 1'b1;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            switch_drive <= 1'b0;
            fault_pulse <= 1'b0;
        end else begin
            switch_drive <= enable && !tripped_r && !expire;
            fault_pulse <= expire;
        end
    end

    timer_count_a: assert property (@(posedge clk) disable iff (srst)
        enable && overcurrent && !tripped_r && cnt_r != LAST |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("fault timer did not advance under overcurrent");
    timer_trip_a: assert property (@(posedge clk) disable iff (srst)
        expire |=> fault_pulse && !switch_drive ##1 !switch_drive || !enable)
        else $error("switch not cut or fault not recorded at expiry");
endmodule

// *** pse_event_i2c.sv ***
// serial target, event request line and port event sources
`timescale 1ns/1ps
`include "pse_event_regs.svh"
module pse_event_i2c #(
    parameter int unsigned FAULT_TMR_CYC = `FAULT_TMR_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic serial_data_in,
    input wire logic addr_strap_b0,
    input wire logic addr_strap_b1,
    input wire logic addr_strap_b2,
    input wire logic addr_strap_b3,
    input wire logic addr_strap_b6,
    input wire pse_event_pkg::port_vec_t port_enable,
    input wire pse_event_pkg::port_vec_t port_current_sense,
    input wire pse_event_pkg::port_vec_t port_output_monitor,
    output pse_event_pkg::port_vec_t port_switch_drive,
    output pse_event_pkg::port_vec_t port_power_good,
    output logic serial_data_out_oe,
    output logic event_req_oe
);
    import pse_event_pkg::*;
    localparam int FAULT_INT_CYC = `FAULT_INT_CYC;
    localparam int STOP_INT_CYC = `STOP_INT_CYC;
    localparam int ARA_REL_CYC = `ARA_REL_CYC;

    // two-flop synchronisers; the first stage feeds only the second
    logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
    logic [4:0] strap_m_r, strap_s_r;
    port_vec_t oc_m_r, oc_s_r, pg_m_r, pg_s_r;
    always_ff @(posedge clk) begin
        scl_m_r <= scl;
        scl_s_r <= scl_m_r;
        scl_d_r <= scl_s_r;
        sda_m_r <= serial_data_in;
        sda_s_r <= sda_m_r;
        sda_d_r <= sda_s_r;
        strap_m_r <= {addr_strap_b6, addr_strap_b3, addr_strap_b2, addr_strap_b1, addr_strap_b0};
        strap_s_r <= strap_m_r;
        oc_m_r <= port_current_sense;
        oc_s_r <= oc_m_r;
        pg_m_r <= port_output_monitor;
        pg_s_r <= pg_m_r;
    end

    wire scl_rise = scl_s_r && !scl_d_r;
    wire scl_fall = !scl_s_r && scl_d_r;
    wire bus_start = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
    wire bus_stop = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

    // straps caught once, on the first cycle after reset release
    logic rst_d_r;
    taddr_t base_r;
    always_ff @(posedge clk) begin
        rst_d_r <= srst;
        if (rst_d_r && !srst) begin
            base_r <= {strap_s_r[4], `ADDR_BIT5, `ADDR_BIT4, strap_s_r[3:0]};
        end
    end

    // port event sources
    port_vec_t fault_p, fault_ev_r, pg_ev_r, mask_f_r, mask_pg_r;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_port
            port_fault_timer #(.LIMIT(FAULT_TMR_CYC)) u_tmr (
                .clk(clk),
                .srst(srst),
                .enable(port_enable[gi]),
                .overcurrent(oc_s_r[gi]),
                .switch_drive(port_switch_drive[gi]),
                .fault_pulse(fault_p[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            port_power_good <= '0;
        end else begin
            port_power_good <= pg_s_r;
        end
    end
    wire port_vec_t pg_set = pg_s_r & ~port_power_good;

    // serial target state
    tgt_state_t st_r;
    logic [3:0] bitcnt_r;
    logic [7:0] rx_r, tx_r, ptr_r, wr_d_r;
    logic [1:0] grp_r;
    logic ptr_ok_r, first_r, rw_r, ara_r, nack_r, busy_r, wr_p_r, ara_ack_p_r;

    wire taddr_t addr_off = rx_r[7:1] - base_r;
    wire dev_hit = addr_off < `ADDR_SPAN;
    wire ara_hit = rx_r[7:1] == `ARA_ADDR && rx_r[0] && event_req_oe;
    wire grp_hi = grp_r[0];
    wire grp_ok = grp_r != 2'd2;
    wire [7:0] grp_sel = !grp_ok ? 8'h00 : grp_hi ? `GRP1_SEL : `GRP0_SEL;
    wire [3:0] fault_g = grp_hi ? fault_ev_r[7:4] : fault_ev_r[3:0];
    wire [3:0] pgev_g = grp_hi ? pg_ev_r[7:4] : pg_ev_r[3:0];
    wire [3:0] mf_g = grp_hi ? mask_f_r[7:4] : mask_f_r[3:0];
    wire [3:0] mpg_g = grp_hi ? mask_pg_r[7:4] : mask_pg_r[3:0];
    wire [3:0] pgood_g = grp_hi ? port_power_good[7:4] : port_power_good[3:0];
    wire [7:0] ptr_eff = ptr_ok_r ? ptr_r : `REG_STATUS;
    wire [7:0] reg_byte = !grp_ok ? 8'h00 :
                          ptr_eff == `REG_STATUS ? {pgev_g, fault_g} :
                          ptr_eff == `REG_MASK ? {mpg_g, mf_g} :
                          ptr_eff == `REG_PGOOD ? {4'h0, pgood_g} : 8'h00;
    wire [7:0] rd_byte = ara_r ? {base_r, 1'b0} : reg_byte;

    // acks and data bits change only on a synced scl fall, so hold time is met
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= S_IDLE;
            bitcnt_r <= '0;
            rx_r <= '0;
            tx_r <= '0;
            ptr_r <= '0;
            wr_d_r <= '0;
            grp_r <= '0;
            {ptr_ok_r, first_r, rw_r, ara_r, nack_r, busy_r} <= '0;
            {wr_p_r, ara_ack_p_r, serial_data_out_oe} <= '0;
        end else begin
            wr_p_r <= 1'b0;
            ara_ack_p_r <= 1'b0;
            if (bus_start) begin
                st_r <= S_ADDR;
                bitcnt_r <= '0;
                busy_r <= 1'b1;
                serial_data_out_oe <= 1'b0;
            end else if (bus_stop) begin
                st_r <= S_IDLE;
                busy_r <= 1'b0;
                ptr_ok_r <= 1'b0;
                serial_data_out_oe <= 1'b0;
            end else if (scl_rise) begin
                if (st_r == S_ADDR || st_r == S_WR) begin
                    rx_r <= {rx_r[6:0], sda_s_r};
                    bitcnt_r <= bitcnt_r + 1'b1;
                end else if (st_r == S_RD) begin
                    bitcnt_r <= bitcnt_r + 1'b1;
                end else if (st_r == S_RD_ACK) begin
                    nack_r <= sda_s_r;
                end
            end else if (scl_fall) begin
                case (st_r)
                    S_IDLE: st_r <= S_IDLE;
                    S_ADDR: if (bitcnt_r == 4'd8) begin
                        if (dev_hit || ara_hit) begin
                            st_r <= S_ACK_A;
                            serial_data_out_oe <= 1'b1;
                            rw_r <= rx_r[0];
                            ara_r <= ara_hit;
                            grp_r <= addr_off[1:0];
                            first_r <= 1'b1;
                        end else begin
                            st_r <= S_IDLE;
                        end
                    end
                    S_ACK_A: begin
                        bitcnt_r <= '0;
                        ara_ack_p_r <= ara_r;
                        if (rw_r) begin
                            st_r <= S_RD;
                            serial_data_out_oe <= ~rd_byte[7];
                            tx_r <= {rd_byte[6:0], 1'b0};
                        end else begin
                            st_r <= S_WR;
                            serial_data_out_oe <= 1'b0;
                        end
                    end
                    S_WR: if (bitcnt_r == 4'd8) begin
                        st_r <= S_ACK_W;
                        serial_data_out_oe <= 1'b1;
                        first_r <= 1'b0;
                        if (first_r) begin
                            ptr_r <= rx_r;
                            ptr_ok_r <= 1'b1;
                        end else begin
                            wr_p_r <= 1'b1;
                            wr_d_r <= rx_r;
                        end
                    end
                    S_ACK_W: begin
                        st_r <= S_WR;
                        serial_data_out_oe <= 1'b0;
                        bitcnt_r <= '0;
                    end
                    S_RD: if (bitcnt_r == 4'd8) begin
                        st_r <= S_RD_ACK;
                        serial_data_out_oe <= 1'b0;
                    end else begin
                        serial_data_out_oe <= ~tx_r[7];
                        tx_r <= {tx_r[6:0], 1'b0};
                    end
                    S_RD_ACK: if (nack_r) begin
                        st_r <= S_IDLE;
                    end else begin
                        st_r <= S_RD;
                        bitcnt_r <= '0;
                        serial_data_out_oe <= ~rd_byte[7];
                        tx_r <= {rd_byte[6:0], 1'b0};
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
        end
    end

    // event flags: a set in the clearing cycle survives
    wire wr_mask = wr_p_r && ptr_r == `REG_MASK;
    wire wr_rel = wr_p_r && ptr_r == `REG_RESET && (wr_d_r[`RST_REL_B6] || wr_d_r[`RST_REL_B7]);
    wire [7:0] clr_sel = wr_rel ? grp_sel : 8'h00;
    wire [7:0] wr_mask8 = {wr_d_r[7:4], wr_d_r[3:0]};
    wire [7:0] mask_f_w = {wr_mask8[3:0], wr_mask8[3:0]};
    wire [7:0] mask_pg_w = {wr_mask8[7:4], wr_mask8[7:4]};
    wire new_ev = |fault_p || |pg_set;
    wire pending = |((fault_ev_r & mask_f_r) | (pg_ev_r & mask_pg_r));
    logic ara_rel_r;
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_ev_r <= '0;
            pg_ev_r <= '0;
            mask_f_r <= `MASK_RST;
            mask_pg_r <= `MASK_RST;
            ara_rel_r <= 1'b0;
            event_req_oe <= 1'b0;
        end else begin
            fault_ev_r <= (fault_ev_r & ~clr_sel) | fault_p;
            pg_ev_r <= (pg_ev_r & ~clr_sel) | pg_set;
            if (wr_mask) begin
                mask_f_r <= (mask_f_r & ~grp_sel) | (mask_f_w & grp_sel);
                mask_pg_r <= (mask_pg_r & ~grp_sel) | (mask_pg_w & grp_sel);
            end
            ara_rel_r <= new_ev ? 1'b0 : (ara_ack_p_r ? 1'b1 : ara_rel_r);
            // frozen while busy: a mid-transfer fault shows after the stop
            if (!busy_r) begin
                event_req_oe <= pending && !ara_rel_r;
            end
        end
    end

    base_addr_a: assert property (@(posedge clk) disable iff (srst || rst_d_r)
        base_r == {strap_s_r[4], 1'b1, 1'b0, strap_s_r[3:0]} || $changed(strap_s_r))
        else $error("base address does not follow straps");
    addr_ack_a: assert property (@(posedge clk) disable iff (srst)
        st_r == S_ADDR && scl_fall && bitcnt_r == 4'd8 && dev_hit && !bus_start && !bus_stop
        |=> serial_data_out_oe && st_r == S_ACK_A)
        else $error("own address not acknowledged");
    int_frozen_a: assert property (@(posedge clk) disable iff (srst)
        $past(busy_r) |-> $stable(event_req_oe))
        else $error("event line changed during transfer");
    int_defer_a: assert property (@(posedge clk) disable iff (srst)
        busy_r && !event_req_oe ##1 busy_r |-> !event_req_oe)
        else $error("event line asserted before stop");
    int_fast_a: assert property (@(posedge clk) disable iff (srst)
        (|fault_p) && !busy_r ##1 !busy_r [*3] |-> ##[0:FAULT_INT_CYC] event_req_oe || busy_r
        || !pending)
        else $error("event line late after fault");
    int_stop_a: assert property (@(posedge clk) disable iff (srst)
        $fell(busy_r) && pending && !ara_rel_r |-> ##[0:STOP_INT_CYC] event_req_oe || busy_r)
        else $error("event line late after stop");
    ara_release_a: assert property (@(posedge clk) disable iff (srst)
        ara_ack_p_r ##1 !new_ev [*2] |-> ##[0:ARA_REL_CYC] !event_req_oe || busy_r || new_ev)
        else $error("event line not released after alert read");
    rel_clear_a: assert property (@(posedge clk) disable iff (srst)
        wr_rel && grp_ok |=> ((fault_ev_r & grp_sel) == ($past(fault_p) & grp_sel)))
        else $error("release write did not clear group events");
    mask_gate_a: assert property (@(posedge clk) disable iff (srst)
        !busy_r && ((fault_ev_r & mask_f_r) | (pg_ev_r & mask_pg_r)) == 8'h00
        |=> !event_req_oe)
        else $error("masked source reached event line");
    pgood_set_a: assert property (@(posedge clk) disable iff (srst)
        pg_s_r != port_power_good |=> port_power_good == $past(pg_s_r))
        else $error("power good not following output monitor");
    short_read_c: cover property (@(posedge clk) st_r == S_RD && !ptr_ok_r && !ara_r);
    ara_read_c: cover property (@(posedge clk) ara_ack_p_r);
    fault_event_c: cover property (@(posedge clk) |fault_p ##[1:20] event_req_oe);
    rel_write_c: cover property (@(posedge clk) wr_rel);
endmodule

// *** pse_event_pkg.sv ***
// types shared by the serial event interface
package pse_event_pkg;
    typedef logic [7:0] port_vec_t;
    typedef logic [6:0] taddr_t;
    typedef enum {S_IDLE, S_ADDR, S_ACK_A, S_WR, S_ACK_W, S_RD, S_RD_ACK} tgt_state_t;
endpackage

// *** pse_event_regs.svh ***
// constants of the serial event interface: timing, addressing, register offsets
// What this block does
// - fault during transfer waits for stop condition
// - answer base address plus next two addresses
// - base address bits from straps, b5=1, b4=0
// - first two addresses select port groups 0-3 and 4-7; the third selects no ports and reads zero
// - event line low within 150 ns of fault
// - deferred event line low within 1.5 us of stop
// - release event line within 1.5 us of alert read
// - fault timer counts while current above threshold
// - timer expiry cuts switch, records fault event
// - power good set when output monitor reports high
// - reset register bits 6/7 release event line
// - mask register suppresses individual event sources
// - event line changes only between transfers
`ifndef PSE_EVENT_REGS_SVH
`define PSE_EVENT_REGS_SVH
`define CLK_MHZ 100
`define FAULT_INT_NS 150
`define FAULT_INT_CYC ((`FAULT_INT_NS * `CLK_MHZ) / 1000)
`define STOP_INT_NS 1500
`define STOP_INT_CYC ((`STOP_INT_NS * `CLK_MHZ) / 1000)
`define ARA_REL_NS 1500
`define ARA_REL_CYC ((`ARA_REL_NS * `CLK_MHZ) / 1000)
`define FAULT_TMR_MS 59
`define FAULT_TMR_CYC (`FAULT_TMR_MS * `CLK_MHZ * 1000)
`define ADDR_BIT5 1'b1
`define ADDR_BIT4 1'b0
`define ADDR_SPAN 7'h03
`define ARA_ADDR 7'h0c
`define REG_STATUS 8'h00
`define REG_MASK 8'h01
`define REG_PGOOD 8'h10
`define REG_RESET 8'h1a
`define RST_REL_B6 6
`define RST_REL_B7 7
`define MASK_RST 8'hff
`define GRP0_SEL 8'h0f
`define GRP1_SEL 8'hf0
`endif

// *** tb.sv ***
// self-checking bench for the serial event interface
`timescale 1ns/1ps
module tb;
    import pse_event_pkg::*;
    localparam int TMR = 20;
    localparam logic [6:0] BASE = 7'h65;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] straps = 5'h15;
    port_vec_t en = 8'h00;
    port_vec_t sense = 8'h00;
    port_vec_t mon = 8'h00;
    port_vec_t sw;
    port_vec_t pg;
    logic sdo_oe;
    logic ev;
    logic scl;
    logic pull;
    wire logic sda = !(pull | sdo_oe);
    int failures = 0;
    int checks = 0;
    always #5 clk = ~clk;
    i2c_host_model i_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
    pse_event_i2c #(.FAULT_TMR_CYC(TMR)) i_dut (
        .clk(clk), .srst(srst), .scl(scl), .serial_data_in(sda),
        .addr_strap_b0(straps[0]), .addr_strap_b1(straps[1]),
        .addr_strap_b2(straps[2]), .addr_strap_b3(straps[3]),
        .addr_strap_b6(straps[4]), .port_enable(en),
        .port_current_sense(sense), .port_output_monitor(mon),
        .port_switch_drive(sw), .port_power_good(pg),
        .serial_data_out_oe(sdo_oe), .event_req_oe(ev));
    task automatic end_of_test();
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
        logic k;
        i_host.start();
        i_host.put({a, 1'b0}, k);
        i_host.put(p, k);
        i_host.put(d, k);
        i_host.stop();
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        logic k;
        i_host.start();
        i_host.put({a, 1'b1}, k);
        i_host.get(1'b1, d);
        i_host.stop();
    endtask
    // bounded wait for the event line to be pulled low
    task automatic ev_wait(input int lim, output int n);
        n = 0;
        while (ev !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic t_addr();
        logic k;
        for (int i = 0; i < 4; i++) begin
            i_host.start();
            i_host.put({BASE + 7'(i), 1'b0}, k);
            i_host.stop();
            chk("addr ack", {7'h0, k}, {7'h0, 1'(i < 3)});
        end
        i_host.start();
        i_host.put(8'h19, k);
        i_host.stop();
        chk("alert idle ack", {7'h0, k}, 8'h00);
    endtask
    task automatic t_fault();
        int n;
        en <= 8'hff;
        cyc(5);
        chk("switch on", sw, 8'hff);
        sense <= 8'h20;
        ev_wait(60, n);
        chk("fault event", {7'h0, ev}, 8'h01);
        chk("fault time", 8'(n >= TMR && n <= TMR + 17), 8'h01);
        chk("switch off", sw, 8'hdf);
        sense <= 8'h00;
    endtask
    task automatic t_short();
        logic [7:0] d;
        rd(BASE + 7'h1, d);
        chk("short read grp1", d, 8'h02);
        rd(BASE, d);
        chk("short read grp0", d, 8'h00);
    endtask
    task automatic t_ara();
        logic k;
        logic [7:0] d;
        i_host.start();
        i_host.put(8'h19, k);
        chk("alert ack", {7'h0, k}, 8'h01);
        i_host.get(1'b1, d);
        chk("alert addr", d, {BASE, 1'b0});
        i_host.stop();
        chk("alert release", {7'h0, ev}, 8'h00);
    endtask
    task automatic t_defer();
        logic k;
        logic bad;
        int n;
        bad = 1'b0;
        i_host.start();
        i_host.put({BASE, 1'b0}, k);
        sense <= 8'h02;
        repeat (60) begin
            @(posedge clk);
            bad = bad | (ev !== 1'b0);
        end
        chk("held in transfer", {7'h0, bad}, 8'h00);
        i_host.stop();
        ev_wait(100, n);
        chk("event after stop", {7'h0, ev}, 8'h01);
        sense <= 8'h00;
    endtask
    task automatic t_mask();
        int n;
        wr(BASE, 8'h1a, 8'h40);
        wr(BASE + 7'h1, 8'h1a, 8'h80);
        cyc(5);
        chk("reset release", {7'h0, ev}, 8'h00);
        wr(BASE, 8'h01, 8'h00);
        mon <= 8'h04;
        cyc(10);
        chk("power good", pg, 8'h04);
        chk("masked event", {7'h0, ev}, 8'h00);
        wr(BASE, 8'h01, 8'hff);
        ev_wait(20, n);
        chk("unmasked event", {7'h0, ev}, 8'h01);
    endtask
    task automatic t_ptr();
        logic k;
        logic [7:0] d;
        i_host.start();
        i_host.put({BASE, 1'b0}, k);
        i_host.put(8'h10, k);
        i_host.rstart();
        i_host.put({BASE, 1'b1}, k);
        chk("ptr read ack", {7'h0, k}, 8'h01);
        i_host.get(1'b1, d);
        i_host.stop();
        chk("pgood read", d, 8'h04);
        rd(BASE + 7'h2, d);
        chk("grp2 read", d, 8'h00);
    endtask
    initial begin
        cyc(80000);
        failures++;
        end_of_test();
    end
    initial begin
        cyc(12);
        srst <= 1'b0;
        cyc(5);
        t_addr();
        t_fault();
        t_short();
        t_ara();
        t_defer();
        t_mask();
        t_ptr();
        end_of_test();
    end
endmodule
